// *** core/switch_matrix_regs.vh ***
`ifndef SWITCH_MATRIX_REGS_VH
`define SWITCH_MATRIX_REGS_VH

// Register byte addresses
`define ADDR_DOUT_GROUP      32'h0000_2150
`define ADDR_NEG_GROUP       32'h0000_2154
`define ADDR_SW_STATE        32'h0000_215c
`define ADDR_SW_CFG          32'h0000_2000

// Reset values
`define DOUT_GROUP_RST       32'h0000_0000
`define NEG_GROUP_RST        32'h0000_0000
`define SW_CFG_RST           32'h0000_0f0f

// Writable bits per register; everything else reads zero
`define DOUT_GROUP_MASK      32'h0000_00df
`define NEG_GROUP_MASK       32'h0000_0c00
`define SW_CFG_MASK          32'h0001_0f0f

// Data-out group field positions
`define DOUT_CAL0_BIT        0
`define DOUT_INPUT1_BIT      1
`define DOUT_INPUT2_BIT      2
`define DOUT_INPUT3_BIT      3
`define DOUT_COUNTER0_BIT    4
`define DNODE_SENSE0_BIT     6
`define DNODE_AUX3_BIT       7

// Negative-node group field positions
`define NEG_TIA_SHORT_BIT    10
`define NEG_ALT_LOOP_BIT     11

// Switch configuration fields
`define SRC_SEL_BIT          16
`define NMUX_MSB             11
`define NMUX_LSB             8
`define DMUX_MSB             3
`define DMUX_LSB             0

// Grouped mux codes
`define DMUX_CAL0            4'h1
`define DMUX_INPUT1          4'h2
`define DMUX_INPUT2          4'h3
`define DMUX_INPUT3          4'h4
`define DMUX_COUNTER0        4'h5
`define DMUX_SENSE0          4'h7
`define DMUX_AUX3            4'h8
`define NMUX_TIA_SHORT       4'h0
`define NMUX_ALT_LOOP_LO     4'hb
`define NMUX_ALT_LOOP_HI     4'he

// Switch vector: data-out bits 7:0, negative bits 9:8
`define SW_COUNT             10

// AXI responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// *** core/switch_group_decode.v ***
`timescale 1ns/1ps
`include "switch_matrix_regs.vh"

module switch_group_decode (
  // Grouped mux codes
  input  wire [3:0] dout_mux_code_i,
  input  wire [3:0] neg_mux_code_i,
  // Decoded enables
  output wire [7:0] dout_group_en_o,
  output wire [1:0] neg_group_en_o
);

  // One-hot decode of the data-out mux code
  function [7:0] dmux_decode;
    input [3:0] code;
    begin
      case (code)
        `DMUX_CAL0:     dmux_decode = 8'h01;
        `DMUX_INPUT1:   dmux_decode = 8'h02;
        `DMUX_INPUT2:   dmux_decode = 8'h04;
        `DMUX_INPUT3:   dmux_decode = 8'h08;
        `DMUX_COUNTER0: dmux_decode = 8'h10;
        `DMUX_SENSE0:   dmux_decode = 8'h40;
        `DMUX_AUX3:     dmux_decode = 8'h80;
        default:        dmux_decode = 8'h00;
      endcase
    end
  endfunction

  // Negative mux: bit 1 alt loopback, bit 0 TIA short
  function [1:0] nmux_decode;
    input [3:0] code;
    begin
      if (code == `NMUX_TIA_SHORT) begin
        nmux_decode = 2'b01;
      end else if ((code >= `NMUX_ALT_LOOP_LO) && (code <= `NMUX_ALT_LOOP_HI)) begin
        nmux_decode = 2'b10;
      end else begin
        nmux_decode = 2'b00;
      end
    end
  endfunction

  // Pure decode; registered by the parent
  assign dout_group_en_o = dmux_decode(dout_mux_code_i);
  assign neg_group_en_o  = nmux_decode(neg_mux_code_i);

endmodule

// *** core/switch_source_select.v ***
`timescale 1ns/1ps
`include "switch_matrix_regs.vh"

module switch_source_select (
  // Source select
  input  wire                 indiv_sel_i,
  // Candidate enables
  input  wire [`SW_COUNT-1:0] indiv_en_i,
  input  wire [`SW_COUNT-1:0] group_en_i,
  // Chosen enables
  output wire [`SW_COUNT-1:0] sw_en_o
);

  genvar i;

  // Per-switch select, each bit on its own path
  generate
    for (i = 0; i < `SW_COUNT; i = i + 1) begin : g_sel
      assign sw_en_o[i] = indiv_sel_i ? indiv_en_i[i] : group_en_i[i];
    end
  endgenerate

endmodule

// *** core/switch_matrix_individual_ctrl.v ***
// Operation
// - Data-out group register at 0x00002150, resets to zero, all open.
// - Negative-node group register at 0x00002154, resets to zero, all open.
// - Each data-out bit except bit 5 drives its own switch; any combination may close.
// - Bit 7 closes D-node to aux electrode three switch.
// - Bit 6 closes D-node to sense electrode zero switch.
// - Bit 4 closes data-out to counter electrode zero switch.
// - Bit 3 closes data-out to analog input three switch.
// - Bit 2 closes data-out to analog input two switch.
// - Bit 1 closes data-out to analog input one switch.
// - Bit 0 closes data-out to calibration resistor zero switch.
// - Each negative-node bit drives its own switch independently.
// - Negative bit 11 closes the alternate loopback switch.
// - Negative bit 10 shorts negative node to high speed TIA input.
// - Individual registers rule only while source select bit 16 is one.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "switch_matrix_regs.vh"

module switch_matrix_individual_ctrl (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        resetn_i,
  // AXI4-Lite write address
  input  wire [31:0] awaddr_i,
  input  wire        awvalid_i,
  output wire        awready_o,
  // AXI4-Lite write data
  input  wire [31:0] wdata_i,
  input  wire [3:0]  wstrb_i,
  input  wire        wvalid_i,
  output wire        wready_o,
  // AXI4-Lite write response
  output wire [1:0]  bresp_o,
  output wire        bvalid_o,
  input  wire        bready_i,
  // AXI4-Lite read address
  input  wire [31:0] araddr_i,
  input  wire        arvalid_i,
  output wire        arready_o,
  // AXI4-Lite read data
  output wire [31:0] rdata_o,
  output wire [1:0]  rresp_o,
  output wire        rvalid_o,
  input  wire        rready_i,
  // Data-out group switch enables
  output wire        dnode_to_aux3_switch_o,
  output wire        dnode_to_sense0_switch_o,
  output wire        dout_to_counter0_switch_o,
  output wire        dout_to_input3_switch_o,
  output wire        dout_to_input2_switch_o,
  output wire        dout_to_input1_switch_o,
  output wire        dout_to_cal0_switch_o,
  // Negative-node group switch enables
  output wire        neg_alt_loopback_switch_o,
  output wire        neg_to_tia_short_switch_o
);

  // Switch enables leave through flops only, so the analog side
  // never sees a decode glitch while a bus write lands.
  // Cost: every switch moves one clock after its register.
  // Limitation: bit 5 of the data-out register has no switch.

  // Register select codes
  // The state view is read-only; writes to it are refused
  localparam SEL_NONE  = 3'd0;
  localparam SEL_DOUT  = 3'd1;
  localparam SEL_NEG   = 3'd2;
  localparam SEL_CFG   = 3'd3;
  localparam SEL_STATE = 3'd4;

  // Storage
  // Group registers keep only their writable bits
  reg  [31:0]           data_out_group_switch_ctrl_r;
  reg  [31:0]           negative_node_group_switch_ctrl_r;
  reg  [31:0]           sw_cfg_r;
  reg  [`SW_COUNT-1:0]  sw_en_r;

  // Write channel holding state
  // Address and data are parked separately; either may come first
  reg                   aw_hold_r;
  reg  [31:0]           awaddr_r;
  reg                   w_hold_r;
  reg  [31:0]           wdata_r;
  reg  [3:0]            wstrb_r;
  reg                   bvalid_r;
  reg  [1:0]            bresp_r;

  // Read channel state
  // Response fields are captured together with rvalid
  reg                   rvalid_r;
  reg  [1:0]            rresp_r;
  reg  [31:0]           rdata_r;

  // Combinational helpers
  // Handshake terms first, then the switch paths
  wire                  aw_fire;
  wire                  w_fire;
  wire                  ar_fire;
  wire                  do_write;
  wire [2:0]            wr_sel;
  wire [2:0]            rd_sel;

  // Switch paths
  wire [7:0]            dout_group_en;
  wire [1:0]            neg_group_en;
  wire [`SW_COUNT-1:0]  indiv_en;
  wire [`SW_COUNT-1:0]  group_en;
  wire [`SW_COUNT-1:0]  sw_en_nxt;
  wire [31:0]           sw_state;

  // Address decode, shared by both channels
  // Byte-lane address bits are ignored; any offset in a word hits it
  function [2:0] addr_decode;
    input [31:0] addr;
    begin
      case ({addr[31:2], 2'b00})
        `ADDR_DOUT_GROUP: addr_decode = SEL_DOUT;
        `ADDR_NEG_GROUP:  addr_decode = SEL_NEG;
        `ADDR_SW_CFG:     addr_decode = SEL_CFG;
        `ADDR_SW_STATE:   addr_decode = SEL_STATE;
        default:          addr_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge, then reserved bits forced to zero
  // Lanes with a low strobe keep their old value
  function [31:0] merge_write;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    input [31:0] mask;
    reg   [31:0] tmp;
    integer      k;
    begin
      tmp = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          tmp[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
      merge_write = tmp & mask;
    end
  endfunction

  // Handshakes; one write and one read in flight at most
  // Ready depends on local flags only, never on valid, so no deadlock
  assign awready_o = ~aw_hold_r & ~bvalid_r;
  assign wready_o  = ~w_hold_r & ~bvalid_r;
  assign arready_o = ~rvalid_r;

  // Transfers completing at this edge
  assign aw_fire   = awvalid_i & awready_o;
  assign w_fire    = wvalid_i & wready_o;
  assign ar_fire   = arvalid_i & arready_o;

  // Write commits once both halves are parked
  assign do_write  = aw_hold_r & w_hold_r & ~bvalid_r;

  // One decoder serves both channels
  assign wr_sel    = addr_decode(awaddr_r);
  assign rd_sel    = addr_decode(araddr_i);

  // Address and data may arrive in either order
  // Each half parks in its own holding register until both are in
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr_i;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
      if (w_fire) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata_i;
        wstrb_r  <= wstrb_i;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped and read-only targets answer SLVERR
  // Refused writes still complete, so the master never hangs
  // bresp is only meaningful while bvalid is high
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      if ((wr_sel == SEL_NONE) || (wr_sel == SEL_STATE)) begin
        bresp_r <= `RESP_SLVERR;
      end else begin
        bresp_r <= `RESP_OKAY;
      end
    end else if (bvalid_r && bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control registers; all switches open out of reset
  // Reserved bits are dropped on the way in, so a stray write
  // to them can never reach a switch
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_out_group_switch_ctrl_r      <= `DOUT_GROUP_RST;
      negative_node_group_switch_ctrl_r <= `NEG_GROUP_RST;
      sw_cfg_r                          <= `SW_CFG_RST;
    end else if (do_write) begin
      case (wr_sel)
        SEL_DOUT: begin
          data_out_group_switch_ctrl_r <= merge_write(data_out_group_switch_ctrl_r,
                                                      wdata_r, wstrb_r,
                                                      `DOUT_GROUP_MASK);
        end
        SEL_NEG: begin
          negative_node_group_switch_ctrl_r <= merge_write(negative_node_group_switch_ctrl_r,
                                                           wdata_r, wstrb_r,
                                                           `NEG_GROUP_MASK);
        end
        SEL_CFG: begin
          sw_cfg_r <= merge_write(sw_cfg_r, wdata_r, wstrb_r, `SW_CFG_MASK);
        end
        default: begin
          sw_cfg_r <= sw_cfg_r;
        end
      endcase
    end
  end

  // Grouped-mux decode from the configuration fields
  // Always decoded; the select below decides which source wins
  // Unused codes decode to all open
  switch_group_decode u_group_decode (
    .dout_mux_code_i (sw_cfg_r[`DMUX_MSB:`DMUX_LSB]),
    .neg_mux_code_i  (sw_cfg_r[`NMUX_MSB:`NMUX_LSB]),
    .dout_group_en_o (dout_group_en),
    .neg_group_en_o  (neg_group_en)
  );

  // Individual bits map one to one onto switches
  // Bit 5 rides along but is masked to zero, so it never closes
  assign indiv_en = {negative_node_group_switch_ctrl_r[`NEG_ALT_LOOP_BIT],
                     negative_node_group_switch_ctrl_r[`NEG_TIA_SHORT_BIT],
                     data_out_group_switch_ctrl_r[7:0]};
  assign group_en = {neg_group_en, dout_group_en};

  // Per-switch source choice; each bit kept separate
  // Flipping the select moves every switch at the same edge
  // No break-before-make: open old paths first if that matters
  switch_source_select u_source_select (
    .indiv_sel_i (sw_cfg_r[`SRC_SEL_BIT]),
    .indiv_en_i  (indiv_en),
    .group_en_i  (group_en),
    .sw_en_o     (sw_en_nxt)
  );

  // Switch enables from flops so analog controls never glitch
  // Async reset opens every pin at once, with no clock needed
  // One flop per switch; no shared decode after the flop
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_en_r <= {`SW_COUNT{1'b0}};
    end else begin
      sw_en_r <= sw_en_nxt;
    end
  end

  // Live switch state, in the same bit layout as the controls
  // Read-only mirror, so software sees what the pins really do
  assign sw_state = {15'h0000,
                     sw_cfg_r[`SRC_SEL_BIT],
                     4'h0,
                     sw_en_r[9:8],
                     2'b00,
                     sw_en_r[7:0]};

  // Read path; unmapped reads return zero with SLVERR
  // Data captured at the address edge, held until taken
  // Reads run independently of any write in progress
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `RESP_OKAY;
      case (rd_sel)
        SEL_DOUT: begin
          rdata_r <= data_out_group_switch_ctrl_r & `DOUT_GROUP_MASK;
        end
        SEL_NEG: begin
          rdata_r <= negative_node_group_switch_ctrl_r & `NEG_GROUP_MASK;
        end
        SEL_CFG: begin
          rdata_r <= sw_cfg_r & `SW_CFG_MASK;
        end
        SEL_STATE: begin
          rdata_r <= sw_state;
        end
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // Write response outputs, straight from flops
  assign bvalid_o = bvalid_r;
  assign bresp_o  = bresp_r;

  // Read response outputs, straight from flops
  assign rvalid_o = rvalid_r;
  assign rresp_o  = rresp_r;
  assign rdata_o  = rdata_r;

  // Switch pins; bit 5 has no switch and is never driven out
  // Data-out group pins
  assign dnode_to_aux3_switch_o    = sw_en_r[`DNODE_AUX3_BIT];
  assign dnode_to_sense0_switch_o  = sw_en_r[`DNODE_SENSE0_BIT];
  assign dout_to_counter0_switch_o = sw_en_r[`DOUT_COUNTER0_BIT];
  assign dout_to_input3_switch_o   = sw_en_r[`DOUT_INPUT3_BIT];
  assign dout_to_input2_switch_o   = sw_en_r[`DOUT_INPUT2_BIT];
  assign dout_to_input1_switch_o   = sw_en_r[`DOUT_INPUT1_BIT];
  assign dout_to_cal0_switch_o     = sw_en_r[`DOUT_CAL0_BIT];

  // Negative-node group pins, top of the enable vector
  assign neg_alt_loopback_switch_o = sw_en_r[9];
  assign neg_to_tia_short_switch_o = sw_en_r[8];

endmodule

// *** tb/switch_matrix_individual_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "switch_matrix_regs.vh"

module switch_matrix_individual_ctrl_checker (
  // Clock and reset
  input wire        core_clk_i,
  input wire        resetn_i,
  // Bus handshakes
  input wire        awvalid_i,
  input wire        awready_o,
  input wire        wvalid_i,
  input wire        wready_o,
  input wire        bvalid_o,
  input wire [31:0] araddr_i,
  input wire        arvalid_i,
  input wire        arready_o,
  input wire [31:0] rdata_o,
  input wire [1:0]  rresp_o,
  input wire        rvalid_o,
  // Switch enables
  input wire        neg_alt_loopback_switch_o,
  input wire        neg_to_tia_short_switch_o,
  input wire        dnode_to_aux3_switch_o,
  input wire        dnode_to_sense0_switch_o,
  input wire        dout_to_counter0_switch_o,
  input wire        dout_to_input3_switch_o,
  input wire        dout_to_input2_switch_o,
  input wire        dout_to_input1_switch_o,
  input wire        dout_to_cal0_switch_o
);
  // All switch enables as one vector, word index of read address
  wire [8:0]  sw = {neg_alt_loopback_switch_o, neg_to_tia_short_switch_o,
                    dnode_to_aux3_switch_o, dnode_to_sense0_switch_o,
                    dout_to_counter0_switch_o, dout_to_input3_switch_o,
                    dout_to_input2_switch_o, dout_to_input1_switch_o,
                    dout_to_cal0_switch_o};
  wire [29:0] ra = araddr_i[31:2];

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Transfer steps
  sequence s_wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_rd_taken;
    arvalid_i && arready_o;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> !awready_o && !wready_o ##1 bvalid_o)
    else $error("write response not on time");
  a_write_block: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_rd_taken |=> rvalid_o)
    else $error("read data not on time");
  a_read_block: assert property (rvalid_o |-> !arready_o)
    else $error("read accepted while data pending");
  a_dout_rsvd: assert property (s_rd_taken ##0 (ra == 30'h854) |=>
    (rdata_o & ~`DOUT_GROUP_MASK) == 32'h0) else $error("data-out reserved bits set");
  a_neg_rsvd: assert property (s_rd_taken ##0 (ra == 30'h855) |=>
    (rdata_o & ~`NEG_GROUP_MASK) == 32'h0) else $error("negative reserved bits set");
  a_unmapped_read: assert property (s_rd_taken ##0 !(ra inside {30'h854, 30'h855, 30'h857,
    30'h800}) |=> rresp_o == `RESP_SLVERR && rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_reset_open: assert property ($rose(resetn_i) |-> sw == 9'h0)
    else $error("switch closed after reset");
  // A switch may only move at an edge where a write response was pending
  a_switch_cause: assert property ($changed(sw) |-> $past(bvalid_o))
    else $error("switch moved without a write");
endmodule

bind switch_matrix_individual_ctrl switch_matrix_individual_ctrl_checker i_chk (
  .core_clk_i, .resetn_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o,
  .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
  .neg_alt_loopback_switch_o, .neg_to_tia_short_switch_o, .dnode_to_aux3_switch_o,
  .dnode_to_sense0_switch_o, .dout_to_counter0_switch_o, .dout_to_input3_switch_o,
  .dout_to_input2_switch_o, .dout_to_input1_switch_o, .dout_to_cal0_switch_o);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "switch_matrix_regs.vh"

module tb_top;
  // Stimulus
  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [31:0] awaddr_i = 32'h0;
  logic        awvalid_i = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0]  wstrb_i = 4'h0;
  logic        wvalid_i = 1'b0;
  logic        bready_i = 1'b0;
  logic [31:0] araddr_i = 32'h0;
  logic        arvalid_i = 1'b0;
  logic        rready_i = 1'b0;
  // Design outputs
  wire         awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  wire [1:0]   bresp_o, rresp_o;
  wire [31:0]  rdata_o;
  wire [8:0]   sw;
  int          bad_count = 0;
  int          check_count = 0;

  switch_matrix_individual_ctrl i_switch_matrix_individual_ctrl (
    .core_clk_i, .resetn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
    .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
    .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
    .neg_alt_loopback_switch_o(sw[8]), .neg_to_tia_short_switch_o(sw[7]),
    .dnode_to_aux3_switch_o(sw[6]), .dnode_to_sense0_switch_o(sw[5]),
    .dout_to_counter0_switch_o(sw[4]), .dout_to_input3_switch_o(sw[3]),
    .dout_to_input2_switch_o(sw[2]), .dout_to_input1_switch_o(sw[1]),
    .dout_to_cal0_switch_o(sw[0]));

  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Write one word; handshakes judged on values settled before each edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ha, hw, hb;
    logic [1:0] r;
    @(posedge core_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= 4'hf;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      #1;
      ha = awvalid_i && awready_o;
      hw = wvalid_i && wready_o;
      hb = bvalid_o && bready_i;
      r = bresp_o;
      @(posedge core_clk_i);
      if (ha) awvalid_i <= 1'b0;
      if (hw) wvalid_i <= 1'b0;
    end
    bready_i <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ht, hr;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge core_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      #1;
      ht = arvalid_i && arready_o;
      hr = rvalid_o && rready_i;
      d = rdata_o;
      r = rresp_o;
      @(posedge core_clk_i);
      if (ht) arvalid_i <= 1'b0;
    end
    rready_i <= 1'b0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Switch pins settle just after the edge ending the response
  task automatic swc(input logic [8:0] e);
    #1;
    chk({23'h0, sw}, {23'h0, e});
  endtask

  function automatic logic [8:0] exp_sw(input logic [31:0] d, input logic [31:0] n);
    exp_sw = {n[11:10], d[7:6], d[4:0]};
  endfunction

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`ADDR_DOUT_GROUP, `DOUT_GROUP_RST, `RESP_OKAY);
    rd(`ADDR_NEG_GROUP, `NEG_GROUP_RST, `RESP_OKAY);
    swc(9'h0);
    wr(`ADDR_SW_CFG, 32'h0001_0f0f, `RESP_OKAY);
    // Single one across every bit, reserved bit 5 included
    for (int b = 0; b < 8; b++) begin
      wr(`ADDR_DOUT_GROUP, 32'h1 << b, `RESP_OKAY);
      swc(exp_sw(32'h1 << b, 32'h0));
      rd(`ADDR_DOUT_GROUP, (32'h1 << b) & `DOUT_GROUP_MASK, `RESP_OKAY);
    end
    // Data-out bit 7 is still closed from the last pass above
    for (int b = 8; b < 13; b++) begin
      wr(`ADDR_NEG_GROUP, 32'h1 << b, `RESP_OKAY);
      swc(exp_sw(32'h0000_0080, 32'h1 << b));
    end
    wr(`ADDR_DOUT_GROUP, 32'hffff_ffff, `RESP_OKAY);
    wr(`ADDR_NEG_GROUP, 32'hffff_ffff, `RESP_OKAY);
    swc(9'h1ff);
    rd(`ADDR_DOUT_GROUP, 32'h0000_00df, `RESP_OKAY);
    rd(`ADDR_NEG_GROUP, 32'h0000_0c00, `RESP_OKAY);
    // Grouped codes take over while source select is low
    wr(`ADDR_SW_CFG, 32'h0000_0b05, `RESP_OKAY);
    swc(9'h110);
    wr(`ADDR_SW_CFG, 32'h0000_0000, `RESP_OKAY);
    swc(9'h080);
    wr(`ADDR_SW_CFG, 32'h0000_0e08, `RESP_OKAY);
    swc(9'h140);
    wr(`ADDR_SW_CFG, 32'h0000_0a03, `RESP_OKAY);
    swc(9'h004);
    wr(`ADDR_SW_CFG, 32'h0001_0f0f, `RESP_OKAY);
    swc(9'h1ff);
    // Refused accesses leave switches alone
    rd(32'h0000_2158, 32'h0, `RESP_SLVERR);
    wr(32'h0000_2158, 32'h0, `RESP_SLVERR);
    wr(`ADDR_SW_STATE, 32'h0, `RESP_SLVERR);
    swc(9'h1ff);
    wr(`ADDR_DOUT_GROUP, 32'h0000_0055, `RESP_OKAY);
    swc(exp_sw(32'h0000_0055, 32'h0000_0c00));
    rd(`ADDR_SW_STATE, 32'h0001_0c55, `RESP_OKAY);
    // Reset in mid-run opens every switch at once
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    swc(9'h0);
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`ADDR_DOUT_GROUP, 32'h0, `RESP_OKAY);
    rd(`ADDR_NEG_GROUP, 32'h0, `RESP_OKAY);
    rd(`ADDR_SW_CFG, `SW_CFG_RST, `RESP_OKAY);
    swc(9'h0);
    tally_and_finish;
  end

  // Watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
endmodule
